// [logic/smc_sleep_ctrl.sv]
// smc_sleep_ctrl: sleep-mode controller with clock/oscillator gating and wake timing
// assumes the core pulses doze_in for one cycle per doze instruction, wake sources
// arrive asynchronously and are synchronised here; memories are outside this block
`timescale 1ns/100ps

module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int STARTUP_CYC = SMC_STARTUP_DEF
)(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        doze_in,
  input  wire logic        any_irq_in,
  input  wire logic        adc_enabled_in,
  input  wire logic        adc_done_irq_in,
  input  wire logic        twi_match_in,
  input  wire logic        async_irq_in,
  input  wire logic        eeprom_ready_in,
  input  wire logic        ext_level_ab_in,
  input  wire logic        ext_irq_line_c_in,
  input  wire logic        sys_reset_in,
  output logic             core_halt_out,
  output logic             core_clk_en_out,
  output logic             flash_clk_en_out,
  output logic             io_clk_en_out,
  output logic             adc_clk_en_out,
  output logic             asy_clk_en_out,
  output logic             main_osc_en_out,
  output logic             adc_start_out,
  output logic             wake_irq_out,
  output logic             wake_reset_out
);

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [7:0]  cfg_r;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] rd_nxt;
  logic        addr_ok;
  smc_state_t  state_r;
  logic [2:0]  mode_r;

  function automatic logic [2:0] mode_of(input logic [7:0] c);
    mode_of = {c[SMC_SM2_BIT], c[SMC_SM1_BIT], c[SMC_SM0_BIT]};
  endfunction : mode_of

  assign addr_ok       = hsel_in && hready_in && htrans_in[1];
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite_in;
      if (addr_ok)
        wr_addr_r <= haddr_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_r <= SMC_CTRL_RST;
      cfg_r  <= SMC_CFG_RST;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r[7:0] == SMC_CTRL_OFS[7:0])
        ctrl_r <= hwdata_in[7:0];
      else if (wr_addr_r[7:0] == SMC_CFG_OFS[7:0])
        cfg_r <= {6'h00, hwdata_in[1:0]};
    end
  end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (haddr_in[7:0])
      SMC_CTRL_OFS[7:0]: rd_nxt = {24'h00_0000, ctrl_r};
      SMC_STAT_OFS[7:0]: rd_nxt = {25'h000_0000, mode_r, state_r};
      SMC_CFG_OFS[7:0]:  rd_nxt = {24'h00_0000, cfg_r};
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      hrdata_out <= 32'h0000_0000;
    else if (addr_ok && !hwrite_in)
      hrdata_out <= rd_nxt;
  end

  // ----------------------------------------------------------------
  // wake source synchronisers
  // ----------------------------------------------------------------
  localparam int NSRC = 8;
  logic [NSRC-1:0] src_raw;
  wire  [NSRC-1:0] sync_w;

  assign src_raw = {sys_reset_in, ext_irq_line_c_in, ext_level_ab_in, eeprom_ready_in,
                    async_irq_in, twi_match_in, adc_done_irq_in, any_irq_in};

  // one flop pair per source; only the second stage is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_sync
      logic s1_r;
      logic s2_r;
      always_ff @(posedge mclk_in)
      begin
        if (!reset_n_in)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end
        else
        begin
          s1_r <= src_raw[gi];
          s2_r <= s1_r;
        end
      end
      assign sync_w[gi] = s2_r;
    end
  endgenerate

  logic s_any, s_adc, s_twi, s_asy, s_eep, s_lvl, s_c, s_rst;
  assign s_any = sync_w[0];
  assign s_adc = sync_w[1];
  assign s_twi = sync_w[2];
  assign s_asy = sync_w[3];
  assign s_eep = sync_w[4];
  assign s_lvl = sync_w[5];
  assign s_c   = sync_w[6];
  assign s_rst = sync_w[7];

  // ----------------------------------------------------------------
  // wake qualification per mode
  // ----------------------------------------------------------------
  logic wake_irq;
  logic asy_on;
  assign asy_on = cfg_r[SMC_CFG_ASYNC];

  always_comb
  begin
    wake_irq = 1'b0;
    case (mode_r)
      SMC_M_IDLE:  wake_irq = s_any;
      SMC_M_NOISE: wake_irq = s_adc || s_twi || s_asy || s_eep || s_lvl || s_c;
      SMC_M_PDOWN,
      SMC_M_STBY:  wake_irq = s_twi || s_lvl || s_c;
      SMC_M_PSAVE,
      SMC_M_XSTBY: wake_irq = s_twi || s_lvl || s_c || (asy_on && s_asy);
      default:     wake_irq = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [15:0] cnt_r;
  logic        arm_ok;
  logic [2:0]  req_mode;
  logic        mode_ok;
  logic        by_rst_r;

  assign req_mode = mode_of(ctrl_r);
  // crystal only for standby modes, reserved codes never sleep
  assign mode_ok = (req_mode != SMC_M_RES4) && (req_mode != SMC_M_RES5) &&
                   (!req_mode[2] || cfg_r[SMC_CFG_XTAL]);
  assign arm_ok  = doze_in && ctrl_r[SMC_ARM_BIT] && mode_ok;
  // arm bit is left set after wake; software must clear it

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      state_r  <= SMC_RUN;
      mode_r   <= SMC_M_IDLE;
      cnt_r    <= SMC_CNT_ZERO;
      by_rst_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        SMC_RUN:
        begin
          by_rst_r <= 1'b0;
          if (arm_ok)
          begin
            state_r <= SMC_SLEEP;
            mode_r  <= req_mode;
          end
        end
        SMC_SLEEP:
        begin
          if (s_rst || wake_irq)
          begin
            by_rst_r <= s_rst;
            state_r  <= SMC_START;
            if (mode_r == SMC_M_PDOWN || mode_r == SMC_M_PSAVE)
              cnt_r <= 16'(STARTUP_CYC - 1);
            else if (mode_r[2])
              cnt_r <= 16'(SMC_STBY_CYC - 1);
            else
              cnt_r <= SMC_CNT_ZERO;
          end
        end
        SMC_START:
        begin
          if (cnt_r == SMC_CNT_ZERO)
          begin
            state_r <= SMC_HALT;
            cnt_r   <= 16'(SMC_HALT_CYC - 1);
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        end
        SMC_HALT:
        begin
          if (cnt_r == SMC_CNT_ZERO)
            state_r <= SMC_RUN;
          else
            cnt_r <= cnt_r - 16'h0001;
        end
        default:
          state_r <= SMC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock and oscillator gating; storage is never reset by sleep
  // ----------------------------------------------------------------
  logic asleep;
  logic deep;
  assign asleep = (state_r == SMC_SLEEP);
  assign deep   = asleep && (mode_r != SMC_M_IDLE) && (mode_r != SMC_M_NOISE);

  // each enable has its own process so a gating change touches one flop
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      core_clk_en_out <= 1'b1;
    else
      core_clk_en_out <= !(asleep || arm_ok);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      flash_clk_en_out <= 1'b1;
    else
      flash_clk_en_out <= !(asleep || arm_ok);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      io_clk_en_out <= 1'b1;
    else
      io_clk_en_out <= !(asleep && mode_r != SMC_M_IDLE);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      adc_clk_en_out <= 1'b1;
    else
      adc_clk_en_out <= !deep;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      asy_clk_en_out <= 1'b1;
    else
      asy_clk_en_out <= !deep || ((mode_r == SMC_M_PSAVE || mode_r == SMC_M_XSTBY)
                        && asy_on);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      main_osc_en_out <= 1'b1;
    else
      main_osc_en_out <= !(deep && !mode_r[2]);
  end

  // ----------------------------------------------------------------
  // core-facing strobes
  // ----------------------------------------------------------------
  // halt rises with the doze that is taken, before the core fetches again
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      core_halt_out <= 1'b0;
    else
      core_halt_out <= (state_r != SMC_RUN) && !(state_r == SMC_HALT && cnt_r == SMC_CNT_ZERO)
                       || arm_ok;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      adc_start_out <= 1'b0;
    else
      adc_start_out <= arm_ok && adc_enabled_in && !req_mode[2] && !req_mode[1];
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      wake_irq_out <= 1'b0;
    else
      wake_irq_out <= (state_r == SMC_HALT) && (cnt_r == SMC_CNT_ZERO) && !by_rst_r;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      wake_reset_out <= 1'b0;
    else
      wake_reset_out <= (state_r == SMC_HALT) && (cnt_r == SMC_CNT_ZERO) && by_rst_r;
  end

endmodule : smc_sleep_ctrl

// [logic/smc_pkg.sv]
// smc_pkg: register map, field positions, mode codes and timing for the sleep controller
// assumes a single 125 MHz clock and an AHB-Lite register slave
package smc_pkg;
  localparam logic [31:0] SMC_CTRL_OFS    = 32'h0000_0000;
  localparam logic [31:0] SMC_STAT_OFS    = 32'h0000_0004;
  localparam logic [31:0] SMC_CFG_OFS     = 32'h0000_0008;
  localparam logic [7:0]  SMC_CTRL_RST    = 8'h00;
  localparam logic [7:0]  SMC_CFG_RST     = 8'h00;
  localparam int          SMC_ARM_BIT     = 6;
  localparam int          SMC_SM2_BIT     = 7;
  localparam int          SMC_SM1_BIT     = 5;
  localparam int          SMC_SM0_BIT     = 4;
  localparam int          SMC_CFG_XTAL    = 0;
  localparam int          SMC_CFG_ASYNC   = 1;
  localparam logic [2:0]  SMC_M_IDLE      = 3'h0;
  localparam logic [2:0]  SMC_M_NOISE     = 3'h1;
  localparam logic [2:0]  SMC_M_PDOWN     = 3'h2;
  localparam logic [2:0]  SMC_M_PSAVE     = 3'h3;
  localparam logic [2:0]  SMC_M_RES4      = 3'h4;
  localparam logic [2:0]  SMC_M_RES5      = 3'h5;
  localparam logic [2:0]  SMC_M_STBY      = 3'h6;
  localparam logic [2:0]  SMC_M_XSTBY     = 3'h7;
  localparam int          SMC_HALT_CYC    = 4;
  localparam int          SMC_STBY_CYC    = 6;
  localparam int          SMC_STARTUP_DEF = 6;
  localparam logic [15:0] SMC_CNT_ZERO    = 16'h0000;
  typedef enum logic [3:0] {
    SMC_RUN   = 4'b0001,
    SMC_SLEEP = 4'b0010,
    SMC_START = 4'b0100,
    SMC_HALT  = 4'b1000
  } smc_state_t;
endpackage : smc_pkg

// [tb/smc_sleep_sva.sv]
// smc_sleep_sva: port-level timing checks for the sleep controller
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
module smc_sleep_sva #(
  parameter int STARTUP_CYC = 6
)(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic core_halt_out,
  input wire logic core_clk_en_out,
  input wire logic flash_clk_en_out,
  input wire logic io_clk_en_out,
  input wire logic main_osc_en_out,
  input wire logic adc_start_out,
  input wire logic wake_irq_out,
  input wire logic wake_reset_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // ----
  // gating
  // ----
  property p_gate; $rose(core_halt_out) |-> !core_clk_en_out && !flash_clk_en_out; endproperty
  a_gate: assert property (p_gate) else $error("core clocks run at halt");
  property p_core_off; $fell(core_clk_en_out) |-> $rose(core_halt_out); endproperty
  a_core_off: assert property (p_core_off) else $error("core clock stopped awake");
  property p_io_off; $fell(io_clk_en_out) |-> core_halt_out; endproperty
  a_io_off: assert property (p_io_off) else $error("io clock stopped awake");
  property p_osc_off; $fell(main_osc_en_out) |-> core_halt_out; endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator stopped awake");
  property p_adc; adc_start_out |-> $rose(core_halt_out); endproperty
  a_adc: assert property (p_adc) else $error("conversion start off entry");
  // ----
  // wake
  // ----
  property p_hold4; $fell(core_halt_out) |-> $past(core_halt_out, 4); endproperty
  a_hold4: assert property (p_hold4) else $error("halt shorter than four");
  property p_excl; !(wake_irq_out && wake_reset_out); endproperty
  a_excl: assert property (p_excl) else $error("both wake kinds");
  property p_resume; wake_irq_out || wake_reset_out |-> ##[0:1] core_clk_en_out; endproperty
  a_resume: assert property (p_resume) else $error("core clock not back");
endmodule : smc_sleep_sva

bind smc_sleep_ctrl smc_sleep_sva #(.STARTUP_CYC(STARTUP_CYC)) sva_u (.*);

// [tb/smc_irq_model.sv]
// smc_irq_model: wake sources around the controller
// assumes sources are raised only while the core is halted
`timescale 1ns/100ps
module smc_irq_model (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       halt_in,
  input  wire logic [6:0] raise_in,
  output logic      [6:0] src_out
);
  logic halt_r;
  // ----
  // level sources held until the core resumes
  // ----
  always_ff @(posedge mclk_in)
  begin
    halt_r <= halt_in;
    if (!reset_n_in || (halt_r && !halt_in))
      src_out <= '0;
    else
      src_out <= src_out | raise_in;
  end
endmodule : smc_irq_model

// [tb/sleep_mode_controller_test.sv]
// sleep_mode_controller_test: register, no-op and per-mode sleep/wake scenarios
// assumes zero-wait bus slave and STARTUP_CYC set to 20 here
`timescale 1ns/100ps
module sleep_mode_controller_test;
  import smc_pkg::*;
  localparam int STARTUP = 20;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        doze = 1'b0;
  logic [6:0]  raise = '0;
  logic [6:0]  src;
  logic [31:0] hrdata;
  logic        hready, halt, core_en, io_en, adc_ck, asy_en, osc_en, adc_st, wk_irq, wk_rst;
  logic        hresp, flash_en;
  int          err_total = 0;
  int          samples_checked = 0;
  always #4 mclk = ~mclk;
  smc_sleep_ctrl #(.STARTUP_CYC(STARTUP)) dut_u (
    .mclk_in(mclk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .doze_in(doze), .any_irq_in(src[0]), .adc_enabled_in(1'b1), .adc_done_irq_in(src[1]),
    .twi_match_in(src[2]), .async_irq_in(src[3]), .eeprom_ready_in(1'b0),
    .ext_level_ab_in(src[4]), .ext_irq_line_c_in(src[5]), .sys_reset_in(src[6]),
    .core_halt_out(halt), .core_clk_en_out(core_en), .flash_clk_en_out(flash_en),
    .io_clk_en_out(io_en), .adc_clk_en_out(adc_ck), .asy_clk_en_out(asy_en),
    .main_osc_en_out(osc_en), .adc_start_out(adc_st), .wake_irq_out(wk_irq),
    .wake_reset_out(wk_rst));
  smc_irq_model irq_u (.mclk_in(mclk), .reset_n_in(rst_n), .halt_in(halt),
    .raise_in(raise), .src_out(src));
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  function automatic logic [31:0] cw(input logic [2:0] m, input logic arm);
    return {24'h0, m[2], arm, m[1], m[0], 4'h0};
  endfunction : cw
  task automatic pulse_doze;
    @(posedge mclk) doze <= 1'b1;
    @(posedge mclk) doze <= 1'b0;
  endtask : pulse_doze
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [31:0] r;
    ahb(1'b0, SMC_CTRL_OFS, '0, r);
    chk("ctrl reset", 32'h0000_0000, r);
    ahb(1'b1, SMC_CTRL_OFS, 32'h0000_00ff, r);
    ahb(1'b0, SMC_CTRL_OFS, '0, r);
    chk("ctrl rw", 32'h0000_00ff, r);
    ahb(1'b0, 32'h0000_000c, '0, r);
    chk("unmapped", 32'h0000_0000, r);
    chk("hresp okay", 32'h0000_0000, {31'h0, hresp});
    $display("test regs done");
  endtask : t_regs
  task automatic t_noop;
    logic [31:0] r;
    ahb(1'b1, SMC_CFG_OFS, '0, r);
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, SMC_CTRL_OFS, (i == 0) ? cw(SMC_M_IDLE, 1'b0) : cw(3'(i + 3), 1'b1), r);
      pulse_doze();
      repeat (3) @(posedge mclk);
      #1 chk("noop gating", 32'h1, {30'h0, halt, core_en});
    end
    $display("test noop done");
  endtask : t_noop
  task automatic do_sleep(input logic [2:0] m, input logic [7:0] cfg, input int s,
                          input int nst, input logic [3:0] en, input logic [6:0] bad,
                          input logic adcs);
    logic [31:0] r;
    int n;
    ahb(1'b1, SMC_CFG_OFS, {24'h0, cfg}, r);
    ahb(1'b1, SMC_CTRL_OFS, cw(m, 1'b1), r);
    pulse_doze();
    #1 chk("adc start", {31'h0, adcs}, {31'h0, adc_st});
    @(posedge mclk);
    #1 chk("gates", {26'h0, 2'b10, en}, {26'h0, halt, core_en, io_en, adc_ck, asy_en, osc_en});
    chk("flash gate", 32'h0, {31'h0, flash_en});
    ahb(1'b0, SMC_STAT_OFS, '0, r);
    chk("status", {25'h0, m, 4'b0010}, r);
    @(posedge mclk) raise <= bad;
    @(posedge mclk) raise <= '0;
    repeat (40) @(posedge mclk);
    #1 chk("ignored source", 32'h1, {31'h0, halt});
    @(posedge mclk) raise <= 7'(1 << s);
    @(posedge mclk) raise <= '0;
    n = 1;
    while (!(wk_irq || wk_rst) && n < 300)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk("wake delay", 32'h1, {31'h0, n >= nst + 3 && n <= nst + 10});
    chk("wake kind", 32'h1, {31'h0, (s == 6) ? wk_rst : wk_irq});
    ahb(1'b1, SMC_CTRL_OFS, '0, r);
    #1 chk("resumed", 32'h1, {30'h0, halt, core_en});
    $display("test sleep mode %0d done", m);
  endtask : do_sleep
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_noop();
    do_sleep(SMC_M_IDLE, 8'h00, 0, 1, 4'b1111, 7'h00, 1'b1);
    do_sleep(SMC_M_NOISE, 8'h00, 1, 1, 4'b0111, 7'h01, 1'b1);
    do_sleep(SMC_M_PDOWN, 8'h00, 2, STARTUP, 4'b0000, 7'h0b, 1'b0);
    do_sleep(SMC_M_PSAVE, 8'h02, 3, STARTUP, 4'b0010, 7'h03, 1'b0);
    do_sleep(SMC_M_STBY, 8'h01, 4, 6, 4'b0001, 7'h0b, 1'b0);
    do_sleep(SMC_M_XSTBY, 8'h03, 5, 6, 4'b0011, 7'h03, 1'b0);
    do_sleep(SMC_M_PDOWN, 8'h00, 6, STARTUP, 4'b0000, 7'h0b, 1'b0);
    report_and_stop();
  end
  // run needs under 2000 cycles; the limit leaves ample slack
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
endmodule : sleep_mode_controller_test
